// >>> eic_top.sv
// external pin interrupt control and flag register with ahb-lite access
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module eic_top
	import eic_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_pin_irq_a,
	input wire logic i_pin_irq_b,
	input wire logic i_pin_irq_c,
	input wire logic i_pin_irq_c_priority,
	output logic o_high_req,
	output logic o_low_req,
	output logic o_irq
);
	// control fields
	logic pin_irq_a_priority;
	logic pin_irq_b_priority;
	logic [EIC_NPIN-1:0] pin_irq_enable;
	logic [EIC_NPIN-1:0] pin_irq_flag;
	// interrupt status and mask
	logic [EIC_NPIN-1:0] status;
	logic [EIC_NPIN-1:0] irq_en;
	// bus pipeline
	logic addr_ok;
	logic wr_pend;
	logic rd_pend;
	logic [7:0] addr_q;
	logic wr_ctrl;
	logic wr_clear;
	logic wr_irq_en;
	logic [7:0] ctrl_view;
	logic [31:0] rd_mux;
	// pin events and request steering
	logic [EIC_NPIN-1:0] pins;
	logic [EIC_NPIN-1:0] evt;
	logic [EIC_NPIN-1:0] req;
	logic [EIC_NPIN-1:0] prio_vec;

	// pin vector: bit 0 is a, bit 1 is b, bit 2 is c
	assign pins = {i_pin_irq_c, i_pin_irq_b, i_pin_irq_a};

	// one edge detector per pin
	for (genvar k = 0; k < EIC_NPIN; k++) begin : g_edge
		eic_edge_det i_eic_edge_det (
			.i_core_clk(i_core_clk),
			.i_rst(i_rst),
			.i_pin(pins[k]),
			.o_event(evt[k])
		);
	end

	// address phase accepted only when the bus is ready
	assign addr_ok = i_hsel & i_htrans[1] & i_hready;

	// address phase capture; reads take one wait state so a write just
	// committed is always visible to the read that follows it
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			wr_pend <= 1'h0;
			rd_pend <= 1'h0;
			addr_q <= EIC_OFF_CTRL;
			o_hreadyout <= 1'h1;
		end else begin
			wr_pend <= addr_ok & i_hwrite;
			rd_pend <= addr_ok & ~i_hwrite;
			if (addr_ok) begin
				addr_q <= i_haddr[7:0];
			end
			o_hreadyout <= ~(addr_ok & ~i_hwrite);
		end
	end

	// response is always okay; upper address bits are not decoded
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_hresp <= EIC_HRESP_OKAY;
		end else begin
			o_hresp <= EIC_HRESP_OKAY;
		end
	end

	// write strobes in the data phase
	assign wr_ctrl = wr_pend && (addr_q == EIC_OFF_CTRL);
	assign wr_clear = wr_pend && (addr_q == EIC_OFF_CLEAR);
	assign wr_irq_en = wr_pend && (addr_q == EIC_OFF_IRQ_EN);

	// priority bits, written in full on a control write
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pin_irq_b_priority <= EIC_CTRL_RST[EIC_PRIO_B_BIT];
			pin_irq_a_priority <= EIC_CTRL_RST[EIC_PRIO_A_BIT];
		end else if (wr_ctrl) begin
			pin_irq_b_priority <= i_hwdata[EIC_PRIO_B_BIT];
			pin_irq_a_priority <= i_hwdata[EIC_PRIO_A_BIT];
		end
	end

	// enable bits
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pin_irq_enable <= EIC_CTRL_RST[EIC_EN_LSB +: EIC_NPIN];
		end else if (wr_ctrl) begin
			pin_irq_enable <= i_hwdata[EIC_EN_LSB +: EIC_NPIN];
		end
	end

	// flags: an edge sets regardless of enable and wins over a clearing write;
	// writing one sets a flag, so software can raise a request itself
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pin_irq_flag <= EIC_CTRL_RST[EIC_FLAG_LSB +: EIC_NPIN];
		end else if (wr_ctrl) begin
			pin_irq_flag <= i_hwdata[EIC_FLAG_LSB +: EIC_NPIN] | evt;
		end else begin
			pin_irq_flag <= pin_irq_flag | evt;
		end
	end

	// sticky status for the interrupt line; set beats write-one-clear
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			status <= EIC_VEC_RST;
		end else if (wr_clear) begin
			status <= (status & ~i_hwdata[EIC_NPIN-1:0]) | evt;
		end else begin
			status <= status | evt;
		end
	end

	// interrupt enable mask
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			irq_en <= EIC_VEC_RST;
		end else if (wr_irq_en) begin
			irq_en <= i_hwdata[EIC_NPIN-1:0];
		end
	end

	// level interrupt, one cycle behind the status it reflects
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_irq <= 1'h0;
		end else begin
			o_irq <= |(status & irq_en);
		end
	end

	// pin c priority lives in another register and arrives as a level
	assign prio_vec = {i_pin_irq_c_priority, pin_irq_b_priority, pin_irq_a_priority};
	assign req = pin_irq_flag & pin_irq_enable;

	// steer enabled flags to the high or low priority request line
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_high_req <= 1'h0;
			o_low_req <= 1'h0;
		end else begin
			o_high_req <= |(req & prio_vec);
			o_low_req <= |(req & ~prio_vec);
		end
	end

	// register view of the control byte
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[EIC_PRIO_B_BIT] = pin_irq_b_priority;
		ctrl_view[EIC_PRIO_A_BIT] = pin_irq_a_priority;
		ctrl_view[EIC_EN_LSB +: EIC_NPIN] = pin_irq_enable;
		ctrl_view[EIC_FLAG_LSB +: EIC_NPIN] = pin_irq_flag;
	end

	// read mux; clear register and unmapped addresses read as zero
	always_comb begin
		rd_mux = EIC_WORD_ZERO;
		case (addr_q)
			EIC_OFF_CTRL: rd_mux[7:0] = ctrl_view;
			EIC_OFF_STATUS: rd_mux[EIC_NPIN-1:0] = status;
			EIC_OFF_IRQ_EN: rd_mux[EIC_NPIN-1:0] = irq_en;
			default: rd_mux = EIC_WORD_ZERO;
		endcase
	end

	// read data loaded in the wait cycle, held until the next read
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_hrdata <= EIC_WORD_ZERO;
		end else if (rd_pend) begin
			o_hrdata <= rd_mux;
		end
	end

	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence s_rd_addr;
		addr_ok && !i_hwrite;
	endsequence

	sequence s_rd_data;
		!o_hreadyout ##1 o_hreadyout;
	endsequence

	a_prio_b_high: assert property (
		(pin_irq_flag[1] && pin_irq_enable[1] && pin_irq_b_priority) |=> o_high_req)
		else $error("pin b high priority request missing");

	a_prio_a_low: assert property (
		(pin_irq_flag[0] && pin_irq_enable[0] && !pin_irq_a_priority) |=> o_low_req)
		else $error("pin a low priority request missing");

	a_enable_blocks: assert property (
		!(|(pin_irq_flag & pin_irq_enable)) |=> !o_high_req && !o_low_req)
		else $error("request raised without an enabled flag");

	a_flag_sets: assert property (
		evt[1] |=> pin_irq_flag[1] ##1 pin_irq_flag[1] || $past(wr_ctrl))
		else $error("pin b edge did not set its flag");

	a_flag_disabled: assert property (
		(evt[2] && !pin_irq_enable[2]) |=> pin_irq_flag[2])
		else $error("flag not set while enable clear");

	a_flag_holds: assert property (
		(pin_irq_flag[0] && !wr_ctrl) |=> pin_irq_flag[0])
		else $error("pin a flag cleared without a write");

	a_read_wait: assert property (
		s_rd_addr |=> s_rd_data ##0 (o_hrdata == $past(rd_mux)))
		else $error("read answer not given after one wait state");

	a_irq_level: assert property (
		(|(status & irq_en)) |=> o_irq)
		else $error("interrupt output low with enabled status");
endmodule

// >>> eic_pkg.sv
// shared constants for the external pin interrupt control block
package eic_pkg;
	// number of external interrupt pins handled here
	localparam int EIC_NPIN = 3;
	// register byte offsets on the bus
	localparam logic [7:0] EIC_OFF_CTRL = 8'h00;
	localparam logic [7:0] EIC_OFF_STATUS = 8'h04;
	localparam logic [7:0] EIC_OFF_CLEAR = 8'h08;
	localparam logic [7:0] EIC_OFF_IRQ_EN = 8'h0c;
	// field positions inside ext_irq_ctrl_third
	localparam int EIC_PRIO_B_BIT = 7;
	localparam int EIC_PRIO_A_BIT = 6;
	localparam int EIC_EN_LSB = 3;
	localparam int EIC_FLAG_LSB = 0;
	// reset values: both priorities high, all enables and flags clear
	localparam logic [7:0] EIC_CTRL_RST = 8'hc0;
	localparam logic [2:0] EIC_VEC_RST = 3'h0;
	localparam logic [31:0] EIC_WORD_ZERO = 32'h0000_0000;
	// ahb encodings
	localparam logic EIC_HRESP_OKAY = 1'h0;
	// idle level assumed on a pin before the first sample
	localparam logic EIC_PIN_IDLE = 1'h1;
endpackage

// >>> eic_edge_det.sv
// rising edge detector for one external interrupt pin
`timescale 1ns/1ps
module eic_edge_det
	import eic_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_pin,
	output logic o_event
);
	logic prev;

	// previous sample; idle-high reset avoids a false event on a pin held high
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			prev <= EIC_PIN_IDLE;
		end else begin
			prev <= i_pin;
		end
	end

	// one-cycle pulse on a low-to-high change
	assign o_event = i_pin & ~prev;
endmodule

// >>> eic_pin_drv.sv
// board-side model driving the three external interrupt pins
`timescale 1ns/1ps
module eic_pin_drv (
	input wire logic i_core_clk,
	input wire logic [2:0] i_fire,
	output logic [2:0] o_pin
);
	logic [2:0] d1 = 3'h0;
	logic [2:0] d2 = 3'h0;
	// two-cycle high pulse per request; low between pulses so every pulse is a fresh edge
	always @(posedge i_core_clk) begin
		d1 <= i_fire;
		d2 <= d1;
	end
	assign o_pin = d1 | d2;
endmodule

// >>> tb_top.sv
// self-checking bench for the external pin interrupt control block
`timescale 1ns/1ps
module tb_top;
	import eic_pkg::*;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, rdp = 0, cprio = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0, pr;
	logic [2:0] fire = 0, pin, m;
	logic hrdy, hresp, hreq, lreq, irq, p;
	logic [31:0] exp_q[$];
	int fails = 0, checked = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	// hsize tied: only whole words are ever sent
	eic_top i_eic_top(.i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
		.i_pin_irq_a(pin[0]), .i_pin_irq_b(pin[1]), .i_pin_irq_c(pin[2]),
		.i_pin_irq_c_priority(cprio), .o_high_req(hreq), .o_low_req(lreq), .o_irq(irq));
	eic_pin_drv i_eic_pin_drv(.i_core_clk(clk), .i_fire(fire), .o_pin(pin));
	task automatic give_verdict;
		// a read whose answer never showed up is a mismatch too
		if (exp_q.size() != 0) fails++;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// bounded wait for hready at a rising edge
	task automatic rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hrdy !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				give_verdict;
			end
			@(posedge clk);
		end
	endtask
	// one single transfer; a read notes its expected word for the monitor
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdp <= !w;
		if (!w) exp_q.push_back(d);
		rdy;
		rdp <= 0;
	endtask
	task automatic pulse(logic [2:0] k);
		fire <= k;
		@(posedge clk);
		fire <= 0;
		repeat (5) @(posedge clk);
	endtask
	// read data taken at the edge that ends the data phase
	always @(posedge clk) begin
		if (rdp && hrdy === 1'b1) begin
			chk("hresp", EIC_HRESP_OKAY, hresp);
			if (exp_q.size() > 0) chk("hrdata", exp_q.pop_front(), hrdata);
		end
	end
	initial begin
		void'($urandom(32'h140b));
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		bus(0, EIC_OFF_CTRL, 32'hc0);
		bus(0, EIC_OFF_STATUS, 32'h0);
		bus(0, EIC_OFF_CLEAR, 32'h0);
		bus(0, 8'h10, 32'h0);
		// poll with every enable off
		pr = 2'($urandom);
		bus(1, EIC_OFF_CTRL, {24'h0, pr, 6'h0});
		bus(0, EIC_OFF_CTRL, {24'h0, pr, 6'h0});
		pulse(3'h7);
		bus(0, EIC_OFF_CTRL, {24'h0, pr, 6'h7});
		chk("high_req", 0, hreq);
		chk("low_req", 0, lreq);
		bus(1, EIC_OFF_CTRL, {24'h0, pr, 6'h0});
		bus(1, EIC_OFF_CLEAR, 32'h7);
		bus(0, EIC_OFF_CTRL, {24'h0, pr, 6'h0});
		// a written one raises a flag by software; a written zero drops it
		bus(1, EIC_OFF_CTRL, {24'h0, pr, 6'h7});
		bus(0, EIC_OFF_CTRL, {24'h0, pr, 6'h7});
		bus(1, EIC_OFF_CTRL, {24'h0, pr, 6'h0});
		bus(0, EIC_OFF_CTRL, {24'h0, pr, 6'h0});
		bus(0, EIC_OFF_STATUS, 32'h0);
		// each pin enabled, a and b at both priorities and c at a random cprio level, then re-armed after clearing
		for (int k = 0; k < 6; k++) begin
			m = 3'h1 << (k % 3);
			p = (k < 3);
			pr = {p, p};
			cprio <= p ^ 1'($urandom) ^ 1'($urandom);
			@(posedge clk);
			p = (k % 3 == 2) ? cprio : p;
			bus(1, EIC_OFF_CTRL, {24'h0, pr, m, 3'h0});
			pulse(m);
			bus(0, EIC_OFF_CTRL, {24'h0, pr, m, m});
			chk("high_req", p, hreq);
			chk("low_req", !p, lreq);
			bus(1, EIC_OFF_IRQ_EN, {29'h0, m});
			repeat (2) @(posedge clk);
			chk("irq", 1, irq);
			bus(1, EIC_OFF_IRQ_EN, 32'h0);
			repeat (2) @(posedge clk);
			chk("irq", 0, irq);
			bus(1, EIC_OFF_CTRL, {24'h0, pr, 6'h0});
			bus(1, EIC_OFF_CLEAR, 32'h7);
			pulse(m);
			bus(0, EIC_OFF_CTRL, {24'h0, pr, 3'h0, m});
			bus(0, EIC_OFF_STATUS, {29'h0, m});
			bus(1, EIC_OFF_CTRL, {24'h0, pr, 6'h0});
			bus(1, EIC_OFF_CLEAR, 32'h7);
		end
		repeat (3) @(posedge clk);
		give_verdict;
	end
endmodule
